// >>> pulse_counter_map.vh
// register offsets, field positions and reset values of the pulse counter
`ifndef PULSE_COUNTER_MAP_VH
`define PULSE_COUNTER_MAP_VH

// byte offsets on the register port
`define OFFSET_COUNTER_CONTROL      8'h00
`define OFFSET_TOP_VALUE            8'h04
`define OFFSET_MAIN_COUNTER         8'h08
`define OFFSET_COUNTER_STATUS       8'h0C
`define OFFSET_INTERRUPT_FLAGS      8'h10
`define OFFSET_OVERSAMPLING_CONFIG  8'h14

// counter_control fields
`define CTRL_MODE_LSB               0
`define CTRL_MODE_MSB               2
`define CTRL_FILTER_BIT             3
`define CTRL_EDGE_BIT               4
`define CTRL_SECOND_DIR_BIT         5
`define CTRL_COUNT_DOWN_BIT         6

// mode field encodings
`define MODE_DISABLED               3'h0
`define MODE_SINGLE_OVS             3'h1
`define MODE_SINGLE_PIN             3'h2
`define MODE_QUAD_PIN               3'h3
`define MODE_QUAD_OVS_X1            3'h4
`define MODE_QUAD_OVS_X2            3'h5
`define MODE_QUAD_OVS_X4            3'h6

// oversampling_config fields
`define OVS_LENGTH_LSB              0
`define OVS_LENGTH_MSB              7
`define OVS_FLUTTER_BIT             8

// interrupt_flags bit positions
`define FLAG_DIR_CHANGE_BIT         0
`define FLAG_OVERFLOW_BIT           1
`define FLAG_UNDERFLOW_BIT          2

// reset values
`define RESET_CONTROL               7'h00
`define RESET_TOP                   16'hFFFF
`define RESET_COUNTER               16'h0000
`define RESET_OVS_CONFIG            9'h000

`endif

// >>> pulse_counter_quadrature_modes.v
// pulse counter with single-input and quadrature decoding modes
//
// What this block does
// RL1: single oversampled mode counts; disabled stops counting
// RL2: edge select inverts primary input
// RL3: single oversampled samples primary on low clock
// RL4: count up by default, down when selected
// RL5: secondary high keeps direction, low reverses
// RL6: pin-clocked single counts primary rising edges
// RL7: no pulse filter in pin-clocked single
// RL8: software picks matching clock source per mode
// RL9: pin-clocked quadrature samples secondary on both edges
// RL10: primary leading means clockwise rotation
// RL11: exactly one sample event enables count
// RL12: pin-clocked quadrature counts on primary rising only
// RL13: direction readable; reversal sets change flag
// RL14: mode field selects 1x, 2x, 4x decoding
// RL15: filter both inputs with configured length
// RL16: 1x counts rising up, falling down
// RL17: 2x both primary edges, 4x all edges
// RL18: state transition table sets plus or minus
// RL19: encoder keeps toggle rate below 8 kHz
// RL20: flutter removal needs two same-direction transitions
// RL21: sixteen bit counter with top register
// RL22: wrap to zero above top, top below zero
// RL23: two-stage synchroniser before edge detection
`timescale 1ns/1ps
`include "pulse_counter_map.vh"

module pulse_counter_quadrature_modes (
  input  wire        clk,
  input  wire        resetn,
  input  wire        primary_input,
  input  wire        secondary_input,
  input  wire        low_frequency_clock,
  input  wire [7:0]  address,
  input  wire [31:0] write_data,
  input  wire        write_strobe,
  input  wire        read_strobe,
  output reg  [31:0] read_data,
  output reg         count_direction,
  output reg         direction_change_flag
);

  // software-visible state
  reg  [2:0]  mode;                        // counting mode
  reg         pulse_filter_enable;         // glitch filter on
  reg         edge_invert;                 // count falling primary edges
  reg         second_input_sets_direction; // secondary steers direction
  reg         count_down_select;           // configured direction
  reg  [15:0] top_value;                   // wrap point
  reg  [15:0] main_counter;                // the count
  reg  [7:0]  filter_length;               // ticks of stability needed, less one
  reg         flutter_removal_enable;      // suppress quick reversals
  reg         overflow_flag;               // wrapped past top
  reg         underflow_flag;              // wrapped below zero

  // synchronisers; first stages feed only second stages
  reg         prim_meta;                   // primary first stage
  reg         prim_sync;                   // primary second stage
  reg         sec_meta;                    // secondary first stage
  reg         sec_sync;                    // secondary second stage
  reg         lfc_meta;                    // low clock first stage
  reg         lfc_sync;                    // low clock second stage
  reg         lfc_last;                    // for low clock edge detect

  // pin-clocked tracking
  reg         pin_last;                    // primary one cycle ago
  reg         sample_at_fall;              // secondary at last primary fall

  // oversampled tracking
  reg         ovs_a_old;                   // previous primary sample
  reg         ovs_b_old;                   // previous secondary sample
  reg         last_move_down;              // direction of last transition
  reg  [7:0]  glitch_count [0:1];          // stability counters
  reg  [1:0]  filtered;                    // filtered {b, a}

  // combinational step decision
  reg         step_valid;                  // counter moves this cycle
  reg         step_down;                   // move is a decrement
  reg         step_quad;                   // move comes from a decoder
  reg  [1:0]  pos_old;                     // gray position before
  reg  [1:0]  pos_new;                     // gray position after
  reg         is_cw;                       // clockwise transition
  reg         is_ccw;                      // counter-clockwise transition
  reg         qualifies;                   // transition counts in mode
  reg  [15:0] next_counter;                // counter after step

  wire        lf_tick;                     // one low clock rising edge
  wire        prim_in;                     // primary after inversion
  wire        pin_rise;                    // primary rising, pin modes
  wire        pin_fall;                    // primary falling, pin modes
  wire        ovs_mode;                    // any oversampled mode
  wire        ovs_quad;                    // oversampled quadrature mode
  wire        use_filter;                  // filter applies now
  wire        ovs_a;                       // primary seen by decoder
  wire        ovs_b;                       // secondary seen by decoder
  wire [1:0]  raw_pair;                    // synced {b, a}

  assign lf_tick  = lfc_sync & ~lfc_last;
  assign prim_in  = prim_sync ^ edge_invert;                   // RL2
  assign pin_rise = prim_in & ~pin_last;
  assign pin_fall = ~prim_in & pin_last;
  assign ovs_quad = (mode == `MODE_QUAD_OVS_X1) |
                    (mode == `MODE_QUAD_OVS_X2) |
                    (mode == `MODE_QUAD_OVS_X4);
  assign ovs_mode = ovs_quad | (mode == `MODE_SINGLE_OVS);
  // pin-clocked modes bypass the filter whatever the enable says
  assign use_filter = pulse_filter_enable & ovs_mode;          // RL7
  assign raw_pair = {sec_sync, prim_in};
  assign ovs_a    = use_filter ? filtered[0] : prim_in;        // RL15
  assign ovs_b    = use_filter ? filtered[1] : sec_sync;       // RL15

  // two flops on each asynchronous input
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prim_meta <= 1'b0;
      prim_sync <= 1'b0;
      sec_meta  <= 1'b0;
      sec_sync  <= 1'b0;
      lfc_meta  <= 1'b0;
      lfc_sync  <= 1'b0;
      lfc_last  <= 1'b0;
      pin_last  <= 1'b0;
    end else begin
      prim_meta <= primary_input;                              // RL23
      prim_sync <= prim_meta;                                  // RL23
      sec_meta  <= secondary_input;                            // RL23
      sec_sync  <= sec_meta;                                   // RL23
      lfc_meta  <= low_frequency_clock;
      lfc_sync  <= lfc_meta;
      lfc_last  <= lfc_sync;

      // one cycle of history for the pin edges
      pin_last  <= prim_in;
    end
  end

  // per-input filter: output follows input after it held steady
  // filter_length+1 low clock ticks; a short spike never gets through
  // filters always run; settled once enabled
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : glitch_filter
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          glitch_count[gi] <= 8'h00;
          filtered[gi]     <= 1'b0;
        end else if (lf_tick) begin
          if (raw_pair[gi] == filtered[gi]) begin
            glitch_count[gi] <= 8'h00;                         // stable
          end else if (glitch_count[gi] >= filter_length) begin
            filtered[gi]     <= raw_pair[gi];                  // RL15
            glitch_count[gi] <= 8'h00;
          end else begin
            glitch_count[gi] <= glitch_count[gi] + 8'h01;
          end
        end
      end
    end
  endgenerate

  // step decision for every mode
  always @* begin
    step_valid = 1'b0;
    step_down  = 1'b0;
    step_quad  = 1'b0;
    pos_old    = {ovs_b_old, ovs_b_old ^ ovs_a_old};
    pos_new    = {ovs_b, ovs_b ^ ovs_a};
    // clockwise walks 00,01,11,10 as {b,a}: gray position rises
    is_cw      = (pos_new == pos_old + 2'd1);                  // RL10
    is_ccw     = (pos_old == pos_new + 2'd1);                  // RL10
    qualifies  = 1'b0;

    // codes 0 and 7 fall to the default
    case (mode)
      `MODE_SINGLE_OVS: begin
        // only active primary edges seen on the low clock count
        if (lf_tick && ovs_a && !ovs_a_old) begin              // RL1 RL3
          step_valid = 1'b1;
        end
        step_down = count_down_select ^                        // RL4
                    (second_input_sets_direction & ~ovs_b);    // RL5
      end

      `MODE_SINGLE_PIN: begin
        step_valid = pin_rise;                                 // RL6
        step_down  = count_down_select ^
                     (second_input_sets_direction & ~sec_sync); // RL5
      end

      `MODE_QUAD_PIN: begin
        // secondary low at rise and high at fall, or the reverse;
        // equal samples mean a reversal or noise and are dropped
        step_valid = pin_rise & (sec_sync ^ sample_at_fall);   // RL11 RL12
        step_down  = sec_sync;                                 // RL11
        step_quad  = 1'b1;
      end
      `MODE_QUAD_OVS_X1,
      `MODE_QUAD_OVS_X2,
      `MODE_QUAD_OVS_X4: begin
        step_quad = 1'b1;
        step_down = is_ccw;                                    // RL18
        if (mode == `MODE_QUAD_OVS_X4) begin
          qualifies = is_cw | is_ccw;                          // RL17
        end else if (mode == `MODE_QUAD_OVS_X2) begin
          qualifies = (is_cw | is_ccw) & (ovs_a != ovs_a_old); // RL17
        end else begin
          // 00->01 going up, 01->00 going down
          qualifies = (is_cw & ovs_a & ~ovs_b) |               // RL16
                      (is_ccw & ovs_a_old & ~ovs_b_old);       // RL16
        end

        if (lf_tick && qualifies) begin                        // RL14
          // flutter removal trades one lost step per reversal
          // for far fewer direction change events
          step_valid = ~flutter_removal_enable |
                       (last_move_down == is_ccw);             // RL20
        end
      end
      default: begin
        step_valid = 1'b0;                                     // RL1
      end
    endcase
  end

  // counter wraps at the configured top value
  always @* begin
    // a top of zero holds the count at zero
    if (step_down) begin
      next_counter = (main_counter == 16'h0000) ? top_value :  // RL22
                     main_counter - 16'h0001;
    end else begin
      next_counter = (main_counter >= top_value) ? 16'h0000 :  // RL22
                     main_counter + 16'h0001;
    end
  end

  // decoder history and counter update
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ovs_a_old       <= 1'b0;
      ovs_b_old       <= 1'b0;
      sample_at_fall  <= 1'b0;
      last_move_down  <= 1'b0;
      main_counter    <= `RESET_COUNTER;
      count_direction <= 1'b0;
    end else begin
      if (lf_tick) begin
        ovs_a_old <= ovs_a;                                    // RL3
        ovs_b_old <= ovs_b;
        if (ovs_quad && qualifies) begin
          last_move_down <= is_ccw;                            // RL20
        end
      end

      // secondary as seen at the last primary fall
      if (pin_fall) begin
        sample_at_fall <= sec_sync;                            // RL9
      end

      if (step_valid) begin
        main_counter <= next_counter;                          // RL21
      end

      // status shows the direction of the last counted step
      if (step_valid) begin
        count_direction <= step_down;                          // RL13
      end
    end
  end

  // sticky flags; hardware set beats a software clear
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      direction_change_flag <= 1'b0;
      overflow_flag         <= 1'b0;
      underflow_flag        <= 1'b0;
    end else begin
      if (step_valid && step_quad &&
          step_down != count_direction) begin
        direction_change_flag <= 1'b1;                         // RL13
      end else if (write_strobe &&
                   address == `OFFSET_INTERRUPT_FLAGS &&
                   write_data[`FLAG_DIR_CHANGE_BIT]) begin
        direction_change_flag <= 1'b0;
      end

      // up past top wraps to zero
      if (step_valid && !step_down && main_counter >= top_value) begin
        overflow_flag <= 1'b1;
      end else if (write_strobe &&
                   address == `OFFSET_INTERRUPT_FLAGS &&
                   write_data[`FLAG_OVERFLOW_BIT]) begin
        overflow_flag <= 1'b0;
      end

      // down from zero wraps to top
      if (step_valid && step_down && main_counter == 16'h0000) begin
        underflow_flag <= 1'b1;
      end else if (write_strobe &&
                   address == `OFFSET_INTERRUPT_FLAGS &&
                   write_data[`FLAG_UNDERFLOW_BIT]) begin
        underflow_flag <= 1'b0;
      end
    end
  end

  // register writes; clock source choice stays with software (RL8)
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {count_down_select, second_input_sets_direction, edge_invert,
       pulse_filter_enable, mode} <= `RESET_CONTROL;
      top_value              <= `RESET_TOP;
      {flutter_removal_enable, filter_length} <= `RESET_OVS_CONFIG;
    end else if (write_strobe) begin
      case (address)
        `OFFSET_COUNTER_CONTROL: begin
          mode <= write_data[`CTRL_MODE_MSB:`CTRL_MODE_LSB];   // RL1 RL14
          pulse_filter_enable <= write_data[`CTRL_FILTER_BIT];
          edge_invert <= write_data[`CTRL_EDGE_BIT];           // RL2
          second_input_sets_direction <=
            write_data[`CTRL_SECOND_DIR_BIT];
          count_down_select <= write_data[`CTRL_COUNT_DOWN_BIT]; // RL4
        end

        `OFFSET_TOP_VALUE: begin
          top_value <= write_data[15:0];                       // RL21
        end

        `OFFSET_OVERSAMPLING_CONFIG: begin
          filter_length <= write_data[`OVS_LENGTH_MSB:`OVS_LENGTH_LSB];
          flutter_removal_enable <= write_data[`OVS_FLUTTER_BIT];
        end
        default: begin
          // counter, status and flags are not written here
        end
      endcase
    end
  end

  // read data valid in the cycle after the strobe, zero otherwise
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      read_data <= 32'h0000_0000;
    end else if (read_strobe) begin
      case (address)
        `OFFSET_COUNTER_CONTROL:
          read_data <= {25'h000_0000, count_down_select,
                        second_input_sets_direction, edge_invert,
                        pulse_filter_enable, mode};
        `OFFSET_TOP_VALUE:
          read_data <= {16'h0000, top_value};
        `OFFSET_MAIN_COUNTER:
          read_data <= {16'h0000, main_counter};
        `OFFSET_COUNTER_STATUS:
          read_data <= {31'h0000_0000, count_direction};       // RL13
        `OFFSET_INTERRUPT_FLAGS:
          read_data <= {29'h0000_0000, underflow_flag,
                        overflow_flag, direction_change_flag};
        `OFFSET_OVERSAMPLING_CONFIG:
          read_data <= {23'h00_0000, flutter_removal_enable,
                        filter_length};
        default:
          read_data <= 32'h0000_0000;                          // unmapped
      endcase
    end else begin
      // idle cycles read as zero
      read_data <= 32'h0000_0000;
    end
  end

endmodule // pulse_counter_quadrature_modes

// >>> pulse_counter_props.sv
// checker of the pulse counter's port behaviour
`timescale 1ns/1ps
`include "pulse_counter_map.vh"
module pulse_counter_props (
  input wire        clk,
  input wire        resetn,
  input wire        primary_input,
  input wire        secondary_input,
  input wire        low_frequency_clock,
  input wire [7:0]  address,
  input wire [31:0] write_data,
  input wire        write_strobe,
  input wire        read_strobe,
  input wire [31:0] read_data,
  input wire        count_direction,
  input wire        direction_change_flag
);
  reg  [2:0] mode;  // last mode field written
  reg  [3:0] quiet; // slow ticks since a pin last moved
  wire       clr;   // software clears the change flag
  assign clr = write_strobe && address == `OFFSET_INTERRUPT_FLAGS
               && write_data[0];
  // shadow of the mode field, and a saturating quiet-tick count
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode  <= 3'h0;
      quiet <= 4'h0;
    end else begin
      if (write_strobe && address == `OFFSET_COUNTER_CONTROL)
        mode <= write_data[2:0];
      // an inversion write is an edge too
      if ($changed({primary_input, secondary_input}) ||
          (write_strobe && address == `OFFSET_COUNTER_CONTROL))
        quiet <= 4'h0;
      else if ($rose(low_frequency_clock) && quiet != 4'hf)
        quiet <= quiet + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_read_idle_zero:
    assert property (!$past(read_strobe) |-> read_data == 32'h0)
    else $error("read data not zero outside a read");
  a_status_direction:
    assert property (read_strobe && address == `OFFSET_COUNTER_STATUS
      |=> read_data == {31'h0, $past(count_direction)})
    else $error("status read differs from direction");
  a_flag_read_match:
    assert property (read_strobe && address == `OFFSET_INTERRUPT_FLAGS
      |=> read_data[0] == $past(direction_change_flag))
    else $error("flag read differs from flag output");
  a_counter_width:
    assert property (read_strobe && address == `OFFSET_MAIN_COUNTER
      |=> read_data[31:16] == 16'h0)
    else $error("counter read wider than sixteen bits");
  a_unmapped_zero:
    assert property (read_strobe
      && address > `OFFSET_OVERSAMPLING_CONFIG |=> read_data == 32'h0)
    else $error("unmapped read not zero");
  a_flag_sticky:
    assert property (direction_change_flag && !clr
      |=> direction_change_flag)
    else $error("change flag dropped without a clear");
  a_flag_on_reversal:
    assert property ($rose(direction_change_flag)
      |-> mode >= 3'h3 && mode <= 3'h6 && $changed(count_direction))
    else $error("change flag set without a quadrature reversal");
  a_quiet_direction:
    assert property (quiet >= 4'h6 |-> $stable(count_direction))
    else $error("direction moved with quiet pins");
  a_disabled_hold:
    assert property (mode == 3'h0 || mode == 3'h7
      |=> $stable(count_direction))
    else $error("direction moved while disabled");
endmodule // pulse_counter_props

bind pulse_counter_quadrature_modes pulse_counter_props
  u_pulse_counter_props (
  .clk(clk), .resetn(resetn), .primary_input(primary_input),
  .secondary_input(secondary_input),
  .low_frequency_clock(low_frequency_clock), .address(address),
  .write_data(write_data), .write_strobe(write_strobe),
  .read_strobe(read_strobe), .read_data(read_data),
  .count_direction(count_direction),
  .direction_change_flag(direction_change_flag));

// >>> quadrature_encoder_model.sv
// shaft encoder model driving the two phase pins
`timescale 1ns/1ps
module quadrature_encoder_model (
  input  wire clk,
  output reg  primary_input,
  output reg  secondary_input
);
  reg [1:0] phase; // place in the gray cycle
  // 128 cycles is eight slow ticks: well inside the toggle limit
  integer   hold = 128;
  initial begin
    primary_input = 1'b0;
    secondary_input = 1'b0;
    phase = 2'h0;
  end
  // set both pins just after an edge, then hold them
  task drive(input a, input b, input integer n);
    integer k;
    begin
      @(posedge clk);
      primary_input <= a;
      secondary_input <= b;
      phase = {b, a ^ b};
      for (k = 1; k < n; k = k + 1) @(posedge clk);
    end
  endtask
  // one quarter step; primary leads when turning clockwise
  task step(input cw);
    reg [1:0] p;
    begin
      p = cw ? phase + 2'h1 : phase - 2'h1;
      drive(p[0] ^ p[1], p[1], hold);
    end
  endtask
endmodule // quadrature_encoder_model

// >>> tb_top.sv
// testbench: register tasks, scenarios and verdict
`timescale 1ns/1ps
`include "pulse_counter_map.vh"
module tb_top;
  reg         clk;           // 40 MHz system clock
  reg         resetn;        // active-low reset
  reg         lfclk;         // slow oversampling clock
  reg  [7:0]  address;       // register bus
  reg  [31:0] write_data;
  reg         write_strobe;
  reg         read_strobe;
  wire [31:0] read_data;
  wire        count_direction;
  wire        direction_change_flag;
  wire        primary_input; // encoder pins
  wire        secondary_input;
  reg  [31:0] rdata;         // last word read
  reg  [15:0] base;          // counter before a scenario
  integer     n_fail;
  integer     total_checks;
  integer     m;

  always #12.5 clk = ~clk;
  // 16 cycles per tick; its edges land on clk falling edges, never on rising ones
  always #200 lfclk = ~lfclk;

  pulse_counter_quadrature_modes u_pulse_counter_quadrature_modes (
    .clk(clk), .resetn(resetn), .primary_input(primary_input),
    .secondary_input(secondary_input), .low_frequency_clock(lfclk),
    .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .count_direction(count_direction),
    .direction_change_flag(direction_change_flag));
  quadrature_encoder_model u_quadrature_encoder_model (
    .clk(clk), .primary_input(primary_input),
    .secondary_input(secondary_input));

  // verdict, reached from the main sequence or the watchdog
  task report_and_stop;
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // single write cycle
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clk);
      write_strobe <= 1'b0;
    end
  endtask
  // single read; data stand only in the cycle after the strobe
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clk);
      read_strobe <= 1'b0;
      #1 rdata = read_data;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp, input string what);
    begin
      rd(a);
      chk(what, exp, rdata);
    end
  endtask
  task cnt(input [15:0] exp, input string what);
    rdc(`OFFSET_MAIN_COUNTER, {16'h0, exp}, what);
  endtask
  task dirc(input exp);
    chk("direction", {31'h0, exp}, {31'h0, count_direction});
  endtask
  task flagc(input exp);
    begin
      rd(`OFFSET_INTERRUPT_FLAGS);
      chk("change flag", {31'h0, exp}, {31'h0, rdata[0]});
    end
  endtask
  task st(input cw, input integer n);
    integer k;
    for (k = 0; k < n; k = k + 1) u_quadrature_encoder_model.step(cw);
  endtask
  task mark;
    begin
      rd(`OFFSET_MAIN_COUNTER);
      base = rdata[15:0];
    end
  endtask
  // reset values, read-only counter, unmapped place
  task t_regs;
    begin
      rdc(`OFFSET_COUNTER_CONTROL, 32'h0, "control");
      rdc(`OFFSET_TOP_VALUE, 32'h0000_ffff, "top");
      rdc(`OFFSET_COUNTER_STATUS, 32'h0, "status");
      rdc(`OFFSET_INTERRUPT_FLAGS, 32'h0, "flags");
      rdc(`OFFSET_OVERSAMPLING_CONFIG, 32'h0, "config");
      wr(`OFFSET_MAIN_COUNTER, 32'h0000_1234);
      wr(`OFFSET_TOP_VALUE, 32'h0000_00ab);
      cnt(16'h0, "counter");
      rdc(`OFFSET_TOP_VALUE, 32'h0000_00ab, "top");
      rdc(8'h40, 32'h0, "unmapped");
      wr(`OFFSET_TOP_VALUE, 32'h0000_ffff);
    end
  endtask
  // one primary pulse under a control setting
  task one(input [6:0] c, input s, input integer hi, input integer lo);
    begin
      wr(`OFFSET_COUNTER_CONTROL, {25'h0, c});
      u_quadrature_encoder_model.drive(1'b0, s, 128);
      mark;
      u_quadrature_encoder_model.drive(1'b1, s, 128);
      cnt(base + hi[15:0], "count after rise");
      if (hi != 0) dirc(hi < 0);
      u_quadrature_encoder_model.drive(1'b0, s, 128);
      cnt(base + hi[15:0] + lo[15:0], "count after fall");
    end
  endtask
  task t_single;
    begin
      one(7'h01, 1'b0, 1, 0);
      one(7'h41, 1'b0, -1, 0);
      one(7'h11, 1'b0, 0, 1);
      one(7'h21, 1'b1, 1, 0);
      one(7'h21, 1'b0, -1, 0);
      one(7'h61, 1'b0, 1, 0);
      one(7'h00, 1'b0, 0, 0);
      one(7'h07, 1'b0, 0, 0);
      one(7'h02, 1'b0, 1, 0);
      one(7'h62, 1'b1, -1, 0);
      wr(`OFFSET_OVERSAMPLING_CONFIG, 32'h0000_00ff);
      one(7'h0a, 1'b0, 1, 0);
      one(7'h09, 1'b0, 0, 0);
      wr(`OFFSET_OVERSAMPLING_CONFIG, 32'h0);
    end
  endtask
  // pin-clocked quadrature: a reversal loses its first rise
  task t_quad_pin;
    begin
      wr(`OFFSET_COUNTER_CONTROL, 32'h3);
      u_quadrature_encoder_model.drive(1'b0, 1'b0, 128);
      st(1'b1, 4);
      mark;
      st(1'b1, 8);
      cnt(base + 16'h2, "pin quadrature cw");
      dirc(1'b0);
      wr(`OFFSET_INTERRUPT_FLAGS, 32'h7);
      flagc(1'b0);
      st(1'b0, 8);
      cnt(base + 16'h1, "pin quadrature ccw");
      dirc(1'b1);
      flagc(1'b1);
    end
  endtask
  // oversampled 1x, 2x and 4x: per-step and per-cycle counts
  task t_quad_ovs;
    for (m = 0; m < 3; m = m + 1) begin
      wr(`OFFSET_COUNTER_CONTROL, 32'h4 + m);
      st(1'b0, 4);
      wr(`OFFSET_INTERRUPT_FLAGS, 32'h7);
      mark;
      st(1'b1, 1);
      cnt(base + 16'h1, "first cw step");
      st(1'b1, 3);
      cnt(base + (16'h1 << m), "cw cycle");
      dirc(1'b0);
      flagc(1'b1);
      wr(`OFFSET_INTERRUPT_FLAGS, 32'h1);
      st(1'b0, 1);
      cnt(base + (16'h1 << m) - (m == 2 ? 16'h1 : 16'h0),
          "first ccw step");
      st(1'b0, 3);
      cnt(base, "ccw cycle");
      dirc(1'b1);
      flagc(1'b1);
    end
  endtask
  // small top value: wrap both ways
  task t_wrap;
    reg [15:0] e;
    integer k;
    begin
      wr(`OFFSET_TOP_VALUE, 32'h3);
      wr(`OFFSET_INTERRUPT_FLAGS, 32'h7);
      st(1'b1, 1);
      rd(`OFFSET_MAIN_COUNTER);
      e = rdata[15:0];
      for (k = 0; k < 10; k = k + 1) begin
        if (k < 5) e = (e >= 16'h3) ? 16'h0 : e + 16'h1;
        else e = (e == 16'h0) ? 16'h3 : e - 16'h1;
        st(k < 5, 1);
        cnt(e, "wrapped count");
      end
      rd(`OFFSET_INTERRUPT_FLAGS);
      chk("wrap flags", 32'h6, {29'h0, rdata[2:1], 1'b0});
      wr(`OFFSET_TOP_VALUE, 32'h0000_ffff);
    end
  endtask
  // flutter removal: a lone reversal step is dropped
  task t_flutter;
    begin
      wr(`OFFSET_OVERSAMPLING_CONFIG, 32'h0000_0100);
      st(1'b1, 3);
      mark;
      st(1'b0, 1);
      cnt(base, "flutter dropped");
      st(1'b0, 1);
      cnt(base - 16'h1, "flutter kept");
      wr(`OFFSET_OVERSAMPLING_CONFIG, 32'h0);
    end
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    lfclk = 1'b0;
    resetn = 1'b0;
    address = 8'h0;
    write_data = 32'h0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    n_fail = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_single;
    t_quad_pin;
    t_quad_ovs;
    t_wrap;
    t_flutter;
    report_and_stop;
  end
  // watchdog: about four times the expected run
  initial begin
    #1500000;
    n_fail = n_fail + 1;
    report_and_stop;
  end
endmodule // tb_top
